// ==== design/pog_onoff_guard.sv ====
// on/off configuration, fault clear and write lock command logic
//
// Operation
// R1: alarm select 01 routes overcurrent warning to alarm
// R2: code 02h is switch config, resets 17h
// R3: switch config bit 4 reads fixed 1
// R4: command bit 3 gates the serial on bit
// R5: pin bit 2 gates the enable pin
// R6: bit 1 reads 1, pin active high
// R7: bit 0 reads 1, fast turn off
// R8: code 03h clears all fault and status bits
// R9: fault clear drops the alert output
// R10: fault clear never restarts latched-off output
// R11: persisting fault sets its bit again
// R12: fault clear is a bare command code
// R13: write lock takes one byte, resets 00h
// R14: invalid lock pattern flags comm and data errors
// R15: invalid lock pattern means no protection
// R16: serial on needs supply, command bit, pin; the code ignores the pin while bit 2 is clear
// R17: lock patterns 80h, 40h, 20h select writable commands
// R18: blocked writes are discarded
// R19: fixed bits ignore writes, keep read values
`timescale 1ns/10ps
`default_nettype none

module pog_onoff_guard (
    input wire logic clk,
    input wire logic nrst,
    // command port from the bus protocol engine
    input wire logic wr_stb,
    input wire logic [7:0] wr_code,
    input wire logic wr_has_data,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_code,
    output logic [7:0] rd_data,
    output logic wr_allowed,
    // power path
    input wire logic enable_pin,
    input wire logic vin_ok,
    input wire logic fault_shutdown,
    input wire logic input_overcurrent_warn,
    input wire logic [pog_pkg::NUM_FAULTS-1:0] fault_cond,
    output logic output_enable,
    output logic hot_alarm_out,
    // status
    output logic [pog_pkg::NUM_FAULTS-1:0] fault_status,
    output logic comm_error_summary_bit,
    output logic unsupported_data_bit,
    output logic alert_out
);

    // ****************************************
    // helper functions
    // ****************************************

    // true when the lock setting leaves this command code writable;
    // any pattern outside the three locking ones falls to the default
    // arm and protects nothing, so a bad byte never locks the bus up
    function automatic logic lock_permits(
        input logic [2:0] lock,
        input logic [7:0] code
    );
        logic ok;
        ok = 1'b1;
        unique case (lock)
            pog_pkg::WL_ALL: begin
                ok = (code == pog_pkg::CODE_WRITE_LOCK); // R17
            end
            pog_pkg::WL_KEEP_OC: begin
                ok = (code == pog_pkg::CODE_WRITE_LOCK) ||
                     (code == pog_pkg::CODE_OUTPUT_CONTROL); // R17
            end
            pog_pkg::WL_KEEP_OC_PSC: begin
                ok = (code == pog_pkg::CODE_WRITE_LOCK) ||
                     (code == pog_pkg::CODE_OUTPUT_CONTROL) ||
                     (code == pog_pkg::CODE_POWER_SWITCH_CONFIG); // R17
            end
            default: begin
                ok = 1'b1; // R15
            end
        endcase
        return ok;
    endfunction

    // only all-zero or exactly one set bit is a legal lock pattern
    function automatic logic lock_valid(input logic [2:0] lock);
        return (lock == pog_pkg::WL_NONE) || (lock == pog_pkg::WL_ALL) ||
               (lock == pog_pkg::WL_KEEP_OC) ||
               (lock == pog_pkg::WL_KEEP_OC_PSC);
    endfunction

    // read image of the power switch configuration register;
    // only the two writable bits are stored, the fixed ones are
    // rebuilt on every read, so no write can ever disturb them
    function automatic logic [7:0] psc_image(
        input logic cmd_bit,
        input logic cp_bit
    );
        logic [7:0] v;
        v = 8'h00; // reserved bits 7:5 read zero
        v[pog_pkg::PSC_PU_BIT] = 1'b1; // R3
        v[pog_pkg::PSC_CMD_BIT] = cmd_bit;
        v[pog_pkg::PSC_CP_BIT] = cp_bit;
        v[pog_pkg::PSC_PL_BIT] = 1'b1; // R6
        v[pog_pkg::PSC_SP_BIT] = 1'b1; // R7
        return v;
    endfunction

    // ****************************************
    // state
    // ****************************************
    pog_pkg::pog_state_t st_ff;
    pog_pkg::pog_state_t nxt_st;

    logic wr_ok;
    logic on_req;
    logic ser_path;
    logic clr_cmd;
    logic wr_take;
    logic wr_byte;
    logic lock_bad;
    logic count_bad;

    // lock check against the current lock; engine may use it too
    assign wr_ok = lock_permits(st_ff.wlock, wr_code);

    // fault clear is only taken as a bare code while unlocked
    assign clr_cmd = wr_stb && wr_ok && !wr_has_data &&
                     (wr_code == pog_pkg::CODE_FAULT_CLEAR); // R12

    // a write that the lock lets through
    assign wr_take = wr_stb && wr_ok; // R18

    // only a write that carries its byte may land in a register
    assign wr_byte = wr_take && wr_has_data; // R18

    // lock byte whose top three bits name no legal pattern;
    // its top three bits are still stored, so a read shows the pattern the host sent
    assign lock_bad = wr_byte && (wr_code == pog_pkg::CODE_WRITE_LOCK) &&
                      !lock_valid(wr_data[pog_pkg::WL_HI:pog_pkg::WL_LO]);

    // byte count that does not suit fault clear or write lock; the engine
    // passes every frame on, so the length check has to live here
    assign count_bad = wr_take &&
        (((wr_code == pog_pkg::CODE_FAULT_CLEAR) && wr_has_data) ||
         ((wr_code == pog_pkg::CODE_WRITE_LOCK) && !wr_has_data));

    // ****************************************
    // on/off decision
    // ****************************************

    // serial on bit counts only with the command bit; pin high is on
    // with both bits clear nothing can turn the output on
    always_comb begin
        ser_path = st_ff.psc_cmd &&
                   st_ff.output_control[pog_pkg::OC_ON_BIT]; // R4
        unique case ({st_ff.psc_cmd, st_ff.psc_cp})
            2'h3: on_req = ser_path && enable_pin; // R16 R6
            2'h2: on_req = ser_path; // R5
            2'h1: on_req = enable_pin; // R5 R6
            default: on_req = 1'b0; // R4
        endcase
    end

    // ****************************************
    // next state
    // ****************************************

    // one pass computes every register; set always beats clear
    always_comb begin
        nxt_st = st_ff;

        // register writes, discarded when the lock blocks them
        if (wr_byte) begin // R18
            unique case (wr_code)
                pog_pkg::CODE_OUTPUT_CONTROL: begin
                    nxt_st.output_control = wr_data;
                    // soft-off is unsupported and stays zero
                    nxt_st.output_control[pog_pkg::OC_SOFT_OFF_BIT] = 1'b0;
                end
                pog_pkg::CODE_POWER_SWITCH_CONFIG: begin // R2
                    nxt_st.psc_cmd = wr_data[pog_pkg::PSC_CMD_BIT]; // R4
                    nxt_st.psc_cp = wr_data[pog_pkg::PSC_CP_BIT]; // R5 R19
                end
                pog_pkg::CODE_WRITE_LOCK: begin // R13
                    // reserved bits 4:0 are dropped
                    nxt_st.wlock = wr_data[pog_pkg::WL_HI:pog_pkg::WL_LO];
                end
                default: begin
                    nxt_st.wlock = st_ff.wlock;
                end
            endcase
        end

        // fault clear wipes all status at once
        // it never touches the latch-off flag further down
        if (clr_cmd) begin
            nxt_st.fault = '0; // R8
            nxt_st.comm_err = 1'b0; // R8 R9
            nxt_st.unsup_data = 1'b0; // R8 R9
        end

        // a condition still present lands again after the clear
        // set beats clear, so a fault still present is never lost
        nxt_st.fault = nxt_st.fault | fault_cond; // R11

        // bad lock byte flags errors; the decode gives no protection
        if (lock_bad) begin
            nxt_st.comm_err = 1'b1; // R14
            nxt_st.unsup_data = 1'b1; // R14
        end

        // wrong byte count for fault clear or write lock is a data error
        if (count_bad) begin
            nxt_st.comm_err = 1'b1; // R12 R13
            nxt_st.unsup_data = 1'b1;
        end

        // latch-off holds until the on request itself goes away;
        // a fault clear has no path to this flag
        if (fault_shutdown) begin
            nxt_st.latched_off = 1'b1; // R10
        end else if (!on_req) begin
            nxt_st.latched_off = 1'b0;
        end

        // no ramp-down state: off takes effect on the next edge
        // the latch is read from its flop, so a one-cycle shutdown
        // pulse still keeps the output off after it has gone
        nxt_st.out_en = on_req && vin_ok && !fault_shutdown &&
                        !st_ff.latched_off; // R16 R7 R10

        // alarm routing from the overcurrent warning
        // a warning under any other select value is simply dropped
        nxt_st.hot = input_overcurrent_warn &&
                     (st_ff.output_control[pog_pkg::OC_ALARM_HI:
                                           pog_pkg::OC_ALARM_LO] ==
                      pog_pkg::ALARM_SEL_ON); // R1

        // read mux; unknown codes read zero
        // registered, so the data answers the code of the cycle before
        unique case (rd_code)
            pog_pkg::CODE_OUTPUT_CONTROL: begin
                nxt_st.rd_data = st_ff.output_control;
            end
            pog_pkg::CODE_POWER_SWITCH_CONFIG: begin
                nxt_st.rd_data = psc_image(st_ff.psc_cmd,
                                           st_ff.psc_cp); // R2 R19
            end
            pog_pkg::CODE_WRITE_LOCK: begin
                nxt_st.rd_data = {st_ff.wlock, 5'h00}; // R19
            end
            default: begin
                nxt_st.rd_data = 8'h00;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************

    // synchronous reset to the power-on values; the status bits
    // start clear, so the alert output is low out of reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff.output_control <= pog_pkg::RST_OUTPUT_CONTROL;
            st_ff.psc_cmd <=
                pog_pkg::RST_POWER_SWITCH_CONFIG[pog_pkg::PSC_CMD_BIT]; // R4
            st_ff.psc_cp <=
                pog_pkg::RST_POWER_SWITCH_CONFIG[pog_pkg::PSC_CP_BIT]; // R5
            st_ff.wlock <=
                pog_pkg::RST_WRITE_LOCK[pog_pkg::WL_HI:pog_pkg::WL_LO]; // R13
            st_ff.fault <= '0;
            st_ff.comm_err <= 1'b0;
            st_ff.unsup_data <= 1'b0;
            st_ff.latched_off <= 1'b0;
            st_ff.out_en <= 1'b0;
            st_ff.hot <= 1'b0;
            st_ff.rd_data <= 8'h00;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // all outputs but wr_allowed and alert_out straight from flip-flops
    assign rd_data = st_ff.rd_data;
    assign wr_allowed = wr_ok;
    assign output_enable = st_ff.out_en;
    assign hot_alarm_out = st_ff.hot;
    assign fault_status = st_ff.fault;
    assign comm_error_summary_bit = st_ff.comm_err;
    assign unsupported_data_bit = st_ff.unsup_data;
    // alert follows any set status bit, so a clear drops it
    // kept combinational so it falls in the same cycle as the status
    assign alert_out = (|st_ff.fault) || st_ff.comm_err ||
                       st_ff.unsup_data; // R9 R11

endmodule

`default_nettype wire

// ==== design/pog_pkg.sv ====
// constants and state type for the on/off and write guard block
package pog_pkg;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CODE_OUTPUT_CONTROL = 8'h01;
    localparam logic [7:0] CODE_POWER_SWITCH_CONFIG = 8'h02;
    localparam logic [7:0] CODE_FAULT_CLEAR = 8'h03;
    localparam logic [7:0] CODE_WRITE_LOCK = 8'h10;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER_SWITCH_CONFIG = 8'h17;
    localparam logic [7:0] RST_WRITE_LOCK = 8'h00;

    // ****************************************
    // output_control fields
    // ****************************************
    localparam int OC_ON_BIT = 7;
    localparam int OC_SOFT_OFF_BIT = 6;
    localparam int OC_MARGIN_HI = 5;
    localparam int OC_MARGIN_LO = 2;
    localparam int OC_ALARM_HI = 1;
    localparam int OC_ALARM_LO = 0;
    localparam logic [1:0] ALARM_SEL_ON = 2'h1;

    // ****************************************
    // power_switch_config fields
    // ****************************************
    localparam int PSC_PU_BIT = 4;
    localparam int PSC_CMD_BIT = 3;
    localparam int PSC_CP_BIT = 2;
    localparam int PSC_PL_BIT = 1;
    localparam int PSC_SP_BIT = 0;

    // ****************************************
    // write_lock_ctrl fields and patterns
    // ****************************************
    localparam int WL_HI = 7;
    localparam int WL_LO = 5;
    localparam logic [2:0] WL_NONE = 3'h0;
    localparam logic [2:0] WL_ALL = 3'h4;
    localparam logic [2:0] WL_KEEP_OC = 3'h2;
    localparam logic [2:0] WL_KEEP_OC_PSC = 3'h1;

    // ****************************************
    // fault vector width
    // ****************************************
    localparam int NUM_FAULTS = 8;

    // whole state of the guard block
    typedef struct packed {
        logic [7:0] output_control;
        logic psc_cmd;
        logic psc_cp;
        logic [2:0] wlock;
        logic [NUM_FAULTS-1:0] fault;
        logic comm_err;
        logic unsup_data;
        logic latched_off;
        logic out_en;
        logic hot;
        logic [7:0] rd_data;
    } pog_state_t;

endpackage

// ==== sim/pog_host_model.sv ====
// host model issuing command writes and reads
`timescale 1ns/10ps
`default_nettype none
module pog_host (
    input wire logic clk,
    output logic wr_stb,
    output logic [7:0] wr_code,
    output logic wr_has_data,
    output logic [7:0] wr_data,
    output logic [7:0] rd_code,
    input wire logic [7:0] rd_data,
    input wire logic wr_allowed
);
    // idle bus at time zero
    initial begin
        wr_stb = 1'b0;
        wr_code = 8'hFF;
        wr_has_data = 1'b0;
        wr_data = 8'h00;
        rd_code = 8'h00;
    end
    // one whole command per strobe; released code and data lines show the inverse
    task send(input logic [7:0] c, input logic h, input logic [7:0] d);
        @(negedge clk);
        wr_stb = 1'b1;
        wr_code = c;
        wr_has_data = h;
        wr_data = d;
        @(negedge clk);
        wr_stb = 1'b0;
        wr_code = ~c;
        wr_data = ~d;
    endtask
    // read data lands one edge after the code is taken
    task fetch(input logic [7:0] c, output logic [7:0] d);
        @(negedge clk);
        rd_code = c;
        @(negedge clk);
        d = rd_data;
    endtask
    // lock decision is combinational, so look a little after setting
    task probe(input logic [7:0] c, output logic a);
        @(negedge clk);
        wr_code = c;
        #1;
        a = wr_allowed;
    endtask
endmodule
`default_nettype wire

// ==== sim/pog_onoff_guard_assertions.sv ====
// port checker for the on/off and write guard block
`timescale 1ns/10ps
`default_nettype none
module pog_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] wr_code,
    input wire logic [7:0] rd_code,
    input wire logic [7:0] rd_data,
    input wire logic wr_allowed,
    input wire logic vin_ok,
    input wire logic fault_shutdown,
    input wire logic input_overcurrent_warn,
    input wire logic [7:0] fault_cond,
    input wire logic output_enable,
    input wire logic hot_alarm_out,
    input wire logic [7:0] fault_status,
    input wire logic comm_error_summary_bit,
    input wire logic unsupported_data_bit,
    input wire logic alert_out
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    hot_cause_a: assert property (
        hot_alarm_out |-> $past(input_overcurrent_warn))
        else $error("hot alarm without overcurrent warning");
    on_cause_a: assert property (
        output_enable |-> $past(vin_ok && !fault_shutdown))
        else $error("output on without supply or with fault");
    latch_hold_a: assert property (
        fault_shutdown ##1 !fault_shutdown |=> !output_enable)
        else $error("output restarted after latch off");
    rd_zero_a: assert property (
        $past(nrst) && !($past(rd_code) inside
        {8'h01, 8'h02, 8'h03, 8'h10}) |-> rd_data == 8'h00)
        else $error("unknown code read not zero");
    psc_fixed_a: assert property (
        $past(nrst) && $past(rd_code) == 8'h02 |->
        rd_data[7:4] == 4'h1 && rd_data[1:0] == 2'h3)
        else $error("switch config fixed bits wrong");
    lock_resv_a: assert property (
        $past(nrst) && $past(rd_code) == 8'h10 |->
        rd_data[4:0] == 5'h00)
        else $error("lock reserved bits not zero");
    alert_or_a: assert property (
        alert_out == (|fault_status ||
        comm_error_summary_bit || unsupported_data_bit))
        else $error("alert does not follow status");
    fault_set_a: assert property (
        $past(nrst) |->
        (fault_status & $past(fault_cond)) == $past(fault_cond))
        else $error("present fault not flagged");
    lock_cmd_a: assert property (wr_code == 8'h10 |-> wr_allowed)
        else $error("lock command itself refused");
endmodule
`default_nettype wire

// ==== sim/pog_onoff_guard_tb.sv ====
// self-checking bench for the on/off and write guard block
`timescale 1ns/10ps
`default_nettype none
module pog_onoff_guard_tb;
    logic clk, nrst, wr_stb, wr_has_data, wr_allowed, enable_pin, vin_ok;
    logic fault_shutdown, input_overcurrent_warn, output_enable;
    logic hot_alarm_out, comm_error_summary_bit, unsupported_data_bit;
    logic alert_out, a;
    logic [7:0] wr_code, wr_data, rd_code, rd_data, fault_cond;
    logic [7:0] fault_status, v;
    int bad_count = 0;
    int checks = 0;
    // ****************************************
    // design and host
    // ****************************************
    pog_onoff_guard pog_onoff_guard_i (.clk, .nrst, .wr_stb, .wr_code,
        .wr_has_data, .wr_data, .rd_code, .rd_data, .wr_allowed, .enable_pin,
        .vin_ok, .fault_shutdown, .input_overcurrent_warn, .fault_cond,
        .output_enable, .hot_alarm_out, .fault_status, .comm_error_summary_bit,
        .unsupported_data_bit, .alert_out);
    pog_host pog_host_i (.clk, .wr_stb, .wr_code, .wr_has_data, .wr_data,
        .rd_code, .rd_data, .wr_allowed);
    // 100 ns period
    always #50 clk = ~clk;
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task rchk(input string n, input logic [7:0] c, input logic [7:0] e);
        pog_host_i.fetch(c, v);
        chk(n, v, e);
    endtask
    task test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        enable_pin = 1'b0;
        vin_ok = 1'b1;
        fault_shutdown = 1'b0;
        input_overcurrent_warn = 1'b0;
        fault_cond = 8'h00;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        rchk("psc_rst", 8'h02, 8'h17);
        rchk("lock_rst", 8'h10, 8'h00);
        // reset config follows the pin alone
        enable_pin = 1'b1;
        @(negedge clk);
        chk("on_pin", output_enable, 1'b1);
        pog_host_i.send(8'h02, 1'b1, 8'hFF);
        rchk("psc_ff", 8'h02, 8'h1F);
        // both bits set: the on bit and the pin must agree
        pog_host_i.send(8'h01, 1'b1, 8'h80);
        @(negedge clk);
        chk("both_on", output_enable, 1'b1);
        enable_pin = 1'b0;
        @(negedge clk);
        chk("both_pin", output_enable, 1'b0);
        pog_host_i.send(8'h01, 1'b1, 8'h00);
        enable_pin = 1'b1;
        pog_host_i.send(8'h02, 1'b1, 8'h08);
        @(negedge clk);
        chk("cmd_off", output_enable, 1'b0);
        pog_host_i.send(8'h01, 1'b1, 8'h80);
        enable_pin = 1'b0;
        @(negedge clk);
        chk("cmd_on", output_enable, 1'b1);
        vin_ok = 1'b0;
        @(negedge clk);
        chk("uv_off", output_enable, 1'b0);
        vin_ok = 1'b1;
        // every alarm select value, only 01 routes the warning
        input_overcurrent_warn = 1'b1;
        for (int s = 0; s < 4; s++) begin
            pog_host_i.send(8'h01, 1'b1, 8'h80 | 8'(s));
            @(negedge clk);
            chk("hot", hot_alarm_out, s == 1);
        end
        // clear while one fault persists, then clear all
        fault_cond = 8'h05;
        @(negedge clk);
        fault_cond = 8'h04;
        pog_host_i.send(8'h03, 1'b0, 8'h00);
        chk("keep", fault_status, 8'h04);
        fault_cond = 8'h00;
        pog_host_i.send(8'h03, 1'b0, 8'h00);
        chk("alert", alert_out, 1'b0);
        pog_host_i.send(8'h03, 1'b1, 8'h00);
        chk("cnt_err", comm_error_summary_bit, 1'b1);
        // latched off output is not restarted by a clear
        fault_shutdown = 1'b1;
        @(negedge clk);
        fault_shutdown = 1'b0;
        pog_host_i.send(8'h03, 1'b0, 8'h00);
        @(negedge clk);
        chk("latch", output_enable, 1'b0);
        // lock patterns, loosest first, ending fully locked
        for (int i = 2; i >= 0; i--) begin
            pog_host_i.send(8'h10, 1'b1, 8'h80 >> i);
            pog_host_i.probe(8'h01, a);
            chk("oc_ok", a, i > 0);
            pog_host_i.probe(8'h02, a);
            chk("psc_ok", a, i == 2);
        end
        pog_host_i.send(8'h02, 1'b1, 8'hFF);
        rchk("blocked", 8'h02, 8'h1B);
        rchk("lock_rd", 8'h10, 8'h80);
        pog_host_i.send(8'h10, 1'b1, 8'hE0);
        chk("unsupported_data_bit", unsupported_data_bit, 1'b1);
        chk("cml", comm_error_summary_bit, 1'b1);
        pog_host_i.probe(8'h02, a);
        chk("no_lock", a, 1'b1);
        // bad lock protects nothing, so a clear goes through
        pog_host_i.send(8'h03, 1'b0, 8'h00);
        chk("clr_open", alert_out, 1'b0);
        pog_host_i.send(8'h10, 1'b0, 8'h00);
        chk("no_byte", unsupported_data_bit, 1'b1);
        rchk("lock_kept", 8'h10, 8'hE0);
        // off through the config frees the latch, then on again
        pog_host_i.send(8'h02, 1'b1, 8'h00);
        pog_host_i.send(8'h02, 1'b1, 8'h08);
        @(negedge clk);
        chk("restart", output_enable, 1'b1);
        pog_host_i.send(8'h02, 1'b1, 8'h00);
        @(negedge clk);
        chk("both_off", output_enable, 1'b0);
        test_done();
    end
endmodule
bind pog_onoff_guard pog_checker pog_checker_i (.clk, .nrst, .wr_code,
    .rd_code, .rd_data, .wr_allowed, .vin_ok, .fault_shutdown,
    .input_overcurrent_warn, .fault_cond, .output_enable, .hot_alarm_out,
    .fault_status, .comm_error_summary_bit, .unsupported_data_bit, .alert_out);
`default_nettype wire
